// ===== rtl/tx_command_word_parser.sv
/*
 * Transmit command word parser.  The host writes, through one APB data
 * port, the first command word, the second command word and then the
 * buffer data words.  The block strips offset and filler, forwards the
 * valid bytes, checks the packet length and publishes per-packet
 * options.  Assumes one clock, pclk, and a byte stream sink that may
 * stall; a stalled sink holds pready low on buffer data word writes.
 */
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// R1: offset of first byte in word A 20:16
// R2: host writes zeros to reserved bits
// R3: word A bit 13 marks first segment
// R4: word A bit 12 marks last segment
// R5: word A bits 10:0 give buffer bytes
// R6: drop filler words from size and alignment
// R7: running size sum mismatch sets error flag
// R8: host size excludes offset and filler bytes
// R9: word B tag goes to packet status
// R10: checksum needs request, first segment, enable
// R11: word B bit 13 suppresses appended CRC
// R12: word B bit 12 suppresses short-frame padding
// R13: pad suppression forces CRC to be appended
// R14: host puts packet length in B 10:0
// R15: length differing from supplied bytes sets error
// R16: both command words precede every buffer
// R17: word B change within packet sets error
// R18: word A 25:24 selects end alignment
// R19: word A bit 31 raises buffer loaded flag
// R20: leading offset bytes are discarded
module tx_command_word_parser
   import tx_cmd_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // byte stream toward the transmitter
   output logic             tx_valid,
   input  wire logic        tx_ready,
   output tx_byte_t         tx_byte,
   // per-packet options and flags
   output pkt_opts_t        pkt_opts,
   output logic             pkt_start,
   output logic             transmit_error_flag,
   output logic             buffer_loaded_flag
);

   typedef enum logic [2:0] {
      ST_CMDA = 3'b001,
      ST_CMDB = 3'b010,
      ST_DATA = 3'b100
   } parse_state_t;

   parse_state_t state_r, state_nxt;

   logic [31:0] cmda_raw_r, cmda_raw_nxt;
   logic [31:0] cmdb_ref_r, cmdb_ref_nxt;
   logic        in_pkt_r, in_pkt_nxt;
   logic [15:0] sum_r, sum_nxt;
   logic [4:0]  skip_r, skip_nxt;
   logic [10:0] left_r, left_nxt;
   logic [10:0] words_r, words_nxt;
   logic        err_r, err_nxt;
   logic        loaded_r, loaded_nxt;
   logic        csum_en_r, csum_en_nxt;
   pkt_opts_t   opts_r, opts_nxt;
   logic        start_r, start_nxt;
   logic [31:0] rdata_r, rdata_nxt;

   cmd_a_t      cmd_a;
   cmd_b_t      cmd_b;
   logic [10:0] buf_words;

   logic        setup;
   logic        access;
   logic        mapped;
   logic        data_wr;
   logic        word_take;
   logic        ctrl_wr;
   logic        stat_wr;
   logic        err_set;
   logic        loaded_set;
   logic [15:0] sum_calc;
   logic [1:0]  lane;
   logic [2:0]  avail;
   logic [2:0]  nbytes;
   logic        eop;
   logic        up_ready;

   tx_cmd_decode u_decode (
      .word_a    (cmda_raw_r),
      .word_b    (pwdata),
      .cmd_a     (cmd_a),
      .cmd_b     (cmd_b),
      .buf_words (buf_words)
   );

   // apb decode
   assign setup   = psel && !penable;
   assign access  = psel && penable;
   assign mapped  = (paddr == ADDR_DATA) || (paddr == ADDR_CTRL) ||
                    (paddr == ADDR_STAT);
   assign data_wr = access && pwrite && (paddr == ADDR_DATA);
   assign ctrl_wr = access && pwrite && (paddr == ADDR_CTRL);
   assign stat_wr = access && pwrite && (paddr == ADDR_STAT);

   // data writes in the data phase wait for the unpacker
   assign pready    = (data_wr && (state_r == ST_DATA)) ? up_ready : 1'b1;
   assign pslverr   = access && !mapped;
   assign prdata    = rdata_r;
   assign word_take = data_wr && pready;

   // valid bytes in the current data word
   always_comb begin
      if (skip_r >= 5'h04) begin
         lane  = 2'h0;
         avail = 3'h0;                                    // see R20
      end else begin
         lane  = skip_r[1:0];                             // see R1
         avail = 3'h4 - {1'b0, skip_r[1:0]};
      end
      if (left_r < {8'h00, avail}) begin
         nbytes = left_r[2:0];
      end else begin
         nbytes = avail;
      end
      eop = cmd_a.last_seg && (left_r == {8'h00, nbytes});
   end

   tx_byte_unpack u_unpack (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_valid  (data_wr && (state_r == ST_DATA)),
      .in_ready  (up_ready),
      .in_word   (pwdata),
      .in_lane   (lane),
      .in_count  (nbytes),
      .in_eop    (eop),
      .out_valid (tx_valid),
      .out_ready (tx_ready),
      .out_byte  (tx_byte)
   );

   assign sum_calc = cmd_a.first_seg ? {5'h00, cmd_a.size}
                                     : sum_r + {5'h00, cmd_a.size};

   // command and data sequencing
   always_comb begin
      state_nxt    = state_r;
      cmda_raw_nxt = cmda_raw_r;
      cmdb_ref_nxt = cmdb_ref_r;
      in_pkt_nxt   = in_pkt_r;
      sum_nxt      = sum_r;
      skip_nxt     = skip_r;
      left_nxt     = left_r;
      words_nxt    = words_r;
      opts_nxt     = opts_r;
      start_nxt    = 1'b0;
      err_set      = 1'b0;
      loaded_set   = 1'b0;
      if (word_take) begin
         unique case (state_r)
            ST_CMDA: begin
               cmda_raw_nxt = pwdata;                     // see R16
               state_nxt    = ST_CMDB;
            end
            ST_CMDB: begin
               if (cmd_a.first_seg) begin                 // see R3
                  cmdb_ref_nxt     = pwdata;
                  start_nxt        = 1'b1;
                  opts_nxt.tag     = cmd_b.tag;           // see R9
                  opts_nxt.csum_on = cmd_b.csum_req &&
                                     csum_en_r;           // see R10
                  opts_nxt.crc_off = cmd_b.crc_dis &&     // see R11
                                     !cmd_b.pad_dis;      // see R13
                  opts_nxt.pad_off = cmd_b.pad_dis;       // see R12
                  if (in_pkt_r) begin
                     err_set = 1'b1;
                  end
               end else if (!in_pkt_r || pwdata != cmdb_ref_r) begin
                  err_set = 1'b1;                         // see R17
               end
               sum_nxt = sum_calc;                        // see R5
               if (cmd_a.last_seg) begin                  // see R4
                  in_pkt_nxt = 1'b0;
                  if (sum_calc != {5'h00, cmd_b.pkt_len}) begin
                     err_set = 1'b1;                      // see R7 R15
                  end
               end else begin
                  in_pkt_nxt = 1'b1;
               end
               skip_nxt  = cmd_a.offset;
               left_nxt  = cmd_a.size;
               words_nxt = buf_words;                     // see R18
               if (buf_words == 11'h000) begin
                  loaded_set = cmd_a.done_irq;            // see R19
                  state_nxt  = ST_CMDA;
               end else begin
                  state_nxt  = ST_DATA;
               end
            end
            ST_DATA: begin
               // words past the last valid byte carry no byte
               skip_nxt  = (skip_r >= 5'h04) ? skip_r - 5'h04 : 5'h00;
               left_nxt  = left_r - {8'h00, nbytes};      // see R6
               words_nxt = words_r - 11'h001;
               if (words_r == 11'h001) begin
                  loaded_set = cmd_a.done_irq;            // see R19
                  state_nxt  = ST_CMDA;
               end
            end
            default: begin
               state_nxt = ST_CMDA;
            end
         endcase
      end
   end

   // flags: a hardware set wins over a software clear
   always_comb begin
      csum_en_nxt = csum_en_r;
      if (ctrl_wr) begin
         csum_en_nxt = pwdata[CTRL_CSUM_EN];
      end
      err_nxt    = (err_r && !(stat_wr && pwdata[STAT_ERR])) || err_set;
      loaded_nxt = (loaded_r && !(stat_wr && pwdata[STAT_LOADED])) ||
                   loaded_set;
   end

   // read data is captured in the setup phase
   always_comb begin
      rdata_nxt = rdata_r;
      if (setup) begin
         rdata_nxt = WORD_RST;
         if (paddr == ADDR_CTRL) begin
            rdata_nxt[CTRL_CSUM_EN] = csum_en_r;
         end else if (paddr == ADDR_STAT) begin
            rdata_nxt[STAT_ERR]    = err_r;
            rdata_nxt[STAT_LOADED] = loaded_r;
            rdata_nxt[STAT_IN_PKT] = in_pkt_r;
            rdata_nxt[31:STAT_TAG_LO] = opts_r.tag;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r    <= ST_CMDA;
         cmda_raw_r <= WORD_RST;
         cmdb_ref_r <= WORD_RST;
         in_pkt_r   <= 1'b0;
         sum_r      <= 16'h0000;
         skip_r     <= 5'h00;
         left_r     <= 11'h000;
         words_r    <= 11'h000;
         err_r      <= 1'b0;
         loaded_r   <= 1'b0;
         csum_en_r  <= CSUM_EN_RST;
         opts_r     <= '0;
         start_r    <= 1'b0;
         rdata_r    <= WORD_RST;
      end else begin
         state_r    <= state_nxt;
         cmda_raw_r <= cmda_raw_nxt;
         cmdb_ref_r <= cmdb_ref_nxt;
         in_pkt_r   <= in_pkt_nxt;
         sum_r      <= sum_nxt;
         skip_r     <= skip_nxt;
         left_r     <= left_nxt;
         words_r    <= words_nxt;
         err_r      <= err_nxt;
         loaded_r   <= loaded_nxt;
         csum_en_r  <= csum_en_nxt;
         opts_r     <= opts_nxt;
         start_r    <= start_nxt;
         rdata_r    <= rdata_nxt;
      end
   end

   assign pkt_opts            = opts_r;
   assign pkt_start           = start_r;
   assign transmit_error_flag = err_r;
   assign buffer_loaded_flag  = loaded_r;

endmodule

`default_nettype wire

// ===== rtl/tx_cmd_pkg.sv
/*
 * Shared constants and types for the transmit command word parser:
 * register offsets, command word field positions, reset values and
 * the packed structs that carry decoded commands and output bytes.
 * Assumes a 32-bit APB register bus with byte addresses.
 */
package tx_cmd_pkg;

   // register byte offsets
   localparam logic [11:0] ADDR_DATA = 12'h000;
   localparam logic [11:0] ADDR_CTRL = 12'h004;
   localparam logic [11:0] ADDR_STAT = 12'h008;

   // first command word field positions
   localparam int A_DONE_IRQ  = 31;
   localparam int A_ALIGN_HI  = 25;
   localparam int A_ALIGN_LO  = 24;
   localparam int A_OFF_HI    = 20;
   localparam int A_OFF_LO    = 16;
   localparam int A_FIRST     = 13;
   localparam int A_LAST      = 12;
   localparam int A_SIZE_HI   = 10;

   // second command word field positions
   localparam int B_TAG_HI    = 31;
   localparam int B_TAG_LO    = 16;
   localparam int B_CSUM      = 14;
   localparam int B_CRC_DIS   = 13;
   localparam int B_PAD_DIS   = 12;
   localparam int B_LEN_HI    = 10;

   // end alignment codes
   localparam logic [1:0] ALIGN_4  = 2'h0;
   localparam logic [1:0] ALIGN_16 = 2'h1;
   localparam logic [1:0] ALIGN_32 = 2'h2;

   // alignment masks in bytes, minus one
   localparam logic [12:0] MASK_4  = 13'h0003;
   localparam logic [12:0] MASK_16 = 13'h000F;
   localparam logic [12:0] MASK_32 = 13'h001F;

   // control and status bit positions
   localparam int CTRL_CSUM_EN = 0;
   localparam int STAT_ERR     = 0;
   localparam int STAT_LOADED  = 1;
   localparam int STAT_IN_PKT  = 2;
   localparam int STAT_TAG_LO  = 16;

   // reset values
   localparam logic        CSUM_EN_RST = 1'b0;
   localparam logic [31:0] WORD_RST    = 32'h0000_0000;

   typedef struct packed {
      logic        done_irq;
      logic [1:0]  align;
      logic [4:0]  offset;
      logic        first_seg;
      logic        last_seg;
      logic [10:0] size;
   } cmd_a_t;

   typedef struct packed {
      logic [15:0] tag;
      logic        csum_req;
      logic        crc_dis;
      logic        pad_dis;
      logic [10:0] pkt_len;
   } cmd_b_t;

   typedef struct packed {
      logic [15:0] tag;
      logic        csum_on;
      logic        crc_off;
      logic        pad_off;
   } pkt_opts_t;

   typedef struct packed {
      logic [7:0] data;
      logic       eop;
   } tx_byte_t;

endpackage

// ===== rtl/tx_cmd_decode.sv
/*
 * Field decoder for the two transmit command words, plus the number
 * of data words the host sends for the buffer, filler included.
 * Purely combinational; the caller holds the words stable.
 */
`timescale 1ns/100ps
`default_nettype none

module tx_cmd_decode
   import tx_cmd_pkg::*;
(
   // raw command words
   input  wire logic [31:0] word_a,
   input  wire logic [31:0] word_b,
   // decoded fields
   output cmd_a_t           cmd_a,
   output cmd_b_t           cmd_b,
   output logic [10:0]      buf_words
);

   logic [12:0] span;
   logic [12:0] mask;
   logic [12:0] rounded;

   always_comb begin
      cmd_a.done_irq  = word_a[A_DONE_IRQ];
      cmd_a.align     = word_a[A_ALIGN_HI:A_ALIGN_LO];
      cmd_a.offset    = word_a[A_OFF_HI:A_OFF_LO];
      cmd_a.first_seg = word_a[A_FIRST];
      cmd_a.last_seg  = word_a[A_LAST];
      cmd_a.size      = word_a[A_SIZE_HI:0];
      cmd_b.tag       = word_b[B_TAG_HI:B_TAG_LO];
      cmd_b.csum_req  = word_b[B_CSUM];
      cmd_b.crc_dis   = word_b[B_CRC_DIS];
      cmd_b.pad_dis   = word_b[B_PAD_DIS];
      cmd_b.pkt_len   = word_b[B_LEN_HI:0];
   end

   // the reserved alignment code falls back to word alignment
   always_comb begin
      unique case (cmd_a.align)
         ALIGN_16: mask = MASK_16;
         ALIGN_32: mask = MASK_32;
         default:  mask = MASK_4;
      endcase
      span      = {8'h00, cmd_a.offset} + {2'h0, cmd_a.size};
      rounded   = (span + mask) & ~mask;
      buf_words = rounded[12:2];
   end

endmodule

`default_nettype wire

// ===== rtl/tx_byte_unpack.sv
/*
 * Holds one accepted data word and hands its valid bytes out one per
 * cycle, lowest lane first, under valid/ready.  A word carrying no
 * valid byte is swallowed at once.  Single clock, async low reset.
 */
`timescale 1ns/100ps
`default_nettype none

module tx_byte_unpack
   import tx_cmd_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // word side
   input  wire logic        in_valid,
   output logic             in_ready,
   input  wire logic [31:0] in_word,
   input  wire logic [1:0]  in_lane,
   input  wire logic [2:0]  in_count,
   input  wire logic        in_eop,
   // byte side
   output logic             out_valid,
   input  wire logic        out_ready,
   output tx_byte_t         out_byte
);

   logic [31:0] data_r, data_nxt;
   logic [2:0]  cnt_r, cnt_nxt;
   logic        eop_r, eop_nxt;

   // one word in flight keeps the shifter small; the bus stalls meanwhile
   assign in_ready        = (cnt_r == 3'h0);
   assign out_valid       = (cnt_r != 3'h0);
   assign out_byte.data   = data_r[7:0];
   assign out_byte.eop    = eop_r && (cnt_r == 3'h1);

   always_comb begin
      data_nxt = data_r;
      cnt_nxt  = cnt_r;
      eop_nxt  = eop_r;
      if (in_valid && in_ready) begin
         data_nxt = in_word >> {in_lane, 3'h0};
         cnt_nxt  = in_count;
         eop_nxt  = in_eop;
      end else if (out_valid && out_ready) begin
         data_nxt = {8'h00, data_r[31:8]};
         cnt_nxt  = cnt_r - 3'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_r <= WORD_RST;
         cnt_r  <= 3'h0;
         eop_r  <= 1'b0;
      end else begin
         data_r <= data_nxt;
         cnt_r  <= cnt_nxt;
         eop_r  <= eop_nxt;
      end
   end

endmodule

`default_nettype wire

// ===== sim/tx_command_word_parser_asserts.sv
/* Assertion checker for the transmit command word parser.
   Sees only the parser's ports; bound to every parser instance below. */
`timescale 1ns/100ps
`default_nettype none
module tx_command_word_parser_asserts
   import tx_cmd_pkg::*;
(
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   // stream and flags
   input wire logic        tx_valid,
   input wire logic        tx_ready,
   input wire tx_byte_t    tx_byte,
   input wire pkt_opts_t   pkt_opts,
   input wire logic        pkt_start,
   input wire logic        transmit_error_flag,
   input wire logic        buffer_loaded_flag
);
   logic data_wr;
   logic stat_wr;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign data_wr = psel && penable && pwrite && paddr == ADDR_DATA;
   assign stat_wr = psel && penable && pwrite && paddr == ADDR_STAT;

   chk_pad_keeps_crc: assert property (
      pkt_opts.pad_off |-> !pkt_opts.crc_off) else $error("crc dropped");
   chk_opts_at_start: assert property (
      !$stable(pkt_opts) |-> pkt_start) else $error("options moved");
   chk_start_single: assert property (
      pkt_start |=> !pkt_start) else $error("start pulse too long");
   chk_err_sticky: assert property (
      transmit_error_flag && !(stat_wr && pwdata[STAT_ERR])
      |=> transmit_error_flag) else $error("error flag lost");
   chk_err_cause: assert property (
      $rose(transmit_error_flag) |-> $past(data_wr))
      else $error("error flag without command");
   chk_loaded_sticky: assert property (
      buffer_loaded_flag && !(stat_wr && pwdata[STAT_LOADED])
      |=> buffer_loaded_flag) else $error("loaded flag lost");
   chk_loaded_cause: assert property (
      $rose(buffer_loaded_flag) |-> $past(data_wr && pready))
      else $error("loaded flag without data word");
   chk_byte_held: assert property (
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
      else $error("byte changed while stalled");
   chk_eop_ends: assert property (
      tx_valid && tx_ready && tx_byte.eop |=> !tx_valid [*2])
      else $error("bytes after packet end");
endmodule
bind tx_command_word_parser tx_command_word_parser_asserts chk_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte),
   .pkt_opts(pkt_opts), .pkt_start(pkt_start),
   .transmit_error_flag(transmit_error_flag),
   .buffer_loaded_flag(buffer_loaded_flag));
`default_nettype wire

// ===== sim/tx_host_model.sv
/* Host model: APB master that builds command words and buffer data.
   Samples pready, prdata and pslverr at the rising edge ending access. */
`timescale 1ns/100ps
`default_nettype none
module tx_host_model
   import tx_cmd_pkg::*;
(
   // clock
   input  wire logic        pclk,
   // apb master
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end

   // released bus shows inverted values so stale data cannot pass
   task automatic xfer(input logic [11:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (!pready) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        er;
      xfer(a, 1'b1, d, rd, er);
   endtask

   function automatic logic [31:0] mk_a(input logic irq,
      input logic [1:0] al, input logic [4:0] off, input logic first,
      input logic last, input logic [10:0] size);
      return {irq, 5'h00, al, 3'h0, off, 2'h0, first, last, 1'b0,
              size};
   endfunction

   function automatic logic [31:0] mk_b(input logic [15:0] tag,
      input logic ck, input logic crc, input logic pad,
      input logic [10:0] len);
      return {tag, 1'b0, ck, crc, pad, 1'b0, len};
   endfunction

   // data byte at stream position p of a buffer is base plus p
   task automatic send(input logic [31:0] a, input logic [31:0] b,
                       input int words, input logic [7:0] base);
      wr(ADDR_DATA, a);
      wr(ADDR_DATA, b);
      for (int w = 0; w < words; w++) begin
         wr(ADDR_DATA, {8'(base + 4 * w + 3), 8'(base + 4 * w + 2),
                        8'(base + 4 * w + 1), 8'(base + 4 * w)});
      end
   endtask
endmodule
`default_nettype wire

// ===== sim/tx_command_word_parser_tb.sv
/* Self-checking bench for the transmit command word parser.
   Host model drives APB; the bench sinks bytes, stalling on demand. */
`timescale 1ns/100ps
`default_nettype none
module tx_command_word_parser_tb;
   import tx_cmd_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        tx_valid, pkt_start, err_f, loaded_f;
   logic        tx_ready = 1'b0;
   logic        stall = 1'b0;
   tx_byte_t    tx_byte;
   pkt_opts_t   pkt_opts;
   logic [31:0] exp_b;
   logic [8:0]  exp_q[$];
   int          n_fail = 0;
   int          n_compared = 0;
   int          n_start = 0;

   always #20 pclk = ~pclk;
   always @(posedge pclk) tx_ready <= stall ? ~tx_ready : 1'b1;

   tx_command_word_parser tx_command_word_parser_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_byte(tx_byte), .pkt_opts(pkt_opts),
      .pkt_start(pkt_start), .transmit_error_flag(err_f),
      .buffer_loaded_flag(loaded_f));
   tx_host_model tx_host_model_i (
      .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s seen %h expected %h",
                  $time, what, seen, exp);
      end
   endtask

   // handshake is judged at the falling edge, where both sides are settled
   always @(negedge pclk) begin
      if (presetn && pkt_start) n_start++;
      if (presetn && tx_valid && tx_ready) begin
         exp_b = 32'hFFFF_FFFF;
         if (exp_q.size() > 0) exp_b = {23'h0, exp_q.pop_front()};
         check({23'h0, tx_byte}, exp_b, "byte");
      end
   end

   task automatic rd(input logic [11:0] a, output logic [31:0] d,
                     output logic e);
      tx_host_model_i.xfer(a, 1'b0, 32'h0000_0000, d, e);
   endtask

   task automatic seg(input logic first, input logic last,
      input logic [1:0] al, input logic [4:0] off, input logic [10:0] size,
      input logic [31:0] b, input logic [7:0] base);
      int span;
      int words;
      span = (al == ALIGN_16) ? 16 : ((al == ALIGN_32) ? 32 : 4);
      words = int'(off) + int'(size) + span - 1;
      words = words / span * span / 4;
      for (int k = 0; k < int'(size); k++) begin
         exp_q.push_back({8'(base + off + k),
                          last && k == size - 1});
      end
      tx_host_model_i.send(tx_host_model_i.mk_a(1'b1, al, off, first, last,
                           size), b, words, base);
   endtask

   task automatic drain;
      for (int i = 0; i < 500 && exp_q.size() > 0; i++) @(posedge pclk);
      repeat (3) @(posedge pclk);
      check(32'(exp_q.size()), 32'h0, "bytes missing");
   endtask

   task automatic s_basic;
      logic [31:0] d;
      logic        e;
      tx_host_model_i.wr(ADDR_CTRL, 32'h0000_0001);
      rd(ADDR_CTRL, d, e);
      check(d, 32'h0000_0001, "ctrl");
      seg(1'b1, 1'b1, ALIGN_16, 5'h05, 11'h006,
          tx_host_model_i.mk_b(16'h1234, 1'b1, 1'b0, 1'b0, 11'h006), 8'h10);
      drain();
      check(32'(pkt_opts), {13'h0, 16'h1234, 3'h4}, "opts");
      check(32'(n_start), 32'h1, "start pulses");
      rd(ADDR_STAT, d, e);
      check({d[31:16], d[1:0]}, {16'h1234, 2'h2},
            "status");
      tx_host_model_i.wr(ADDR_STAT, 32'h0000_0002);
      @(negedge pclk);
      check({31'h0, loaded_f}, 32'h0, "loaded clear");
   endtask

   // table rows {enable, ck, crc, pad}
   task automatic s_opts;
      logic [3:0] cfg[4];
      logic [3:0] c;
      cfg = '{4'h6, 4'hB, 4'hC, 4'h1};
      for (int i = 0; i < 4; i++) begin
         c = cfg[i];
         tx_host_model_i.wr(ADDR_CTRL, {31'h0, c[3]});
         seg(1'b1, 1'b1, 2'(i % 3), 5'(i * 10 + 1), 11'(i * 3 + 1),
             tx_host_model_i.mk_b(16'(16'hA0 + i), c[2], c[1], c[0],
             11'(i * 3 + 1)), 8'(i * 40));
         drain();
         check(32'(pkt_opts), {13'h0, 16'(16'hA0 + i),
               c[3] & c[2], c[1] & ~c[0],
               c[0]}, "opts");
      end
      check({31'h0, err_f}, 32'h0, "no error");
   endtask

   task automatic s_multi;
      logic [31:0] b;
      b = tx_host_model_i.mk_b(16'h55AA, 1'b0, 1'b0, 1'b0, 11'h007);
      stall = 1'b1;
      seg(1'b1, 1'b0, ALIGN_4, 5'h02, 11'h004, b, 8'h40);
      seg(1'b0, 1'b1, ALIGN_32, 5'h00, 11'h003, b, 8'h80);
      drain();
      stall = 1'b0;
      check({31'h0, err_f}, 32'h0, "split packet");
      check(32'(n_start), 32'h6, "start pulses");
      seg(1'b1, 1'b0, ALIGN_4, 5'h00, 11'h004, b, 8'h20);
      seg(1'b0, 1'b1, ALIGN_4, 5'h00, 11'h003, b ^ 32'h0001_0000, 8'h30);
      drain();
      check({31'h0, err_f}, 32'h1, "word b change");
      tx_host_model_i.wr(ADDR_STAT, 32'h0000_0001);
      @(negedge pclk);
      check({31'h0, err_f}, 32'h0, "error clear");
      seg(1'b1, 1'b1, ALIGN_4, 5'h03, 11'h004,
          tx_host_model_i.mk_b(16'h0042, 1'b0, 1'b0, 1'b0, 11'h005), 8'h60);
      drain();
      check({31'h0, err_f}, 32'h1, "length mismatch");
      tx_host_model_i.wr(ADDR_STAT, 32'h0000_0001);
   endtask

   task automatic s_bus;
      logic [31:0] d;
      logic        e;
      rd(12'h00C, d, e);
      check({e, d[30:0]}, 32'h8000_0000, "unmapped");
      rd(ADDR_DATA, d, e);
      check({e, d[30:0]}, 32'h0, "data read");
   endtask

   task automatic conclude;
      if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      #2000000;
      n_fail++;
      conclude();
   end

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      s_basic();
      s_opts();
      s_multi();
      s_bus();
      conclude();
   end
endmodule
`default_nettype wire
